// >>> hdl/hbridge_control_fault_regs.sv
`timescale 1ns/1ns
// Operation
// - Lone request bit drives that gate, else off
// - Active low-side freewheel: highs off, lows on
// - Active high-side freewheel: lows off, highs on
// - Passive low-side freewheel: only highs off
// - Passive high-side freewheel: only lows off
// - No OV recovery: off until flag cleared
// - No UV recovery: off until flag cleared
// - Mode bit set enters Active
// - Mode bit clear: Standby, clear state, off
// - Over-current sets own flag, switch off
// - Any over-current flag sets fault summary
// - Over-current output off until flag cleared
// - Under-voltage: all off, latch flag
// - UV recovery default: resume when supply recovers
// - Over-voltage: all off, latch flag
// - OV recovery default: resume when supply recovers
// - Dual half-bridge ignores PWM and freewheel bits
// - Settling timer holds not-ready after Active entry
module hbridge_control_fault_regs
  import hbridge_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_DEFAULT
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [5:0]  regAddr,
  input  wire logic [15:0] regWdata,
  output logic      [15:0] regRdata,
  input  wire logic        pwm,
  input  wire logic        dualHalfBridge,
  input  wire logic [3:0]  overcurrentDetect,
  input  wire logic        undervoltageDetect,
  input  wire logic        overvoltageDetect,
  output gate_t            gateOut,
  output logic             notReady,
  output logic             faultSummary
);

  logic        rstnMeta;
  logic        rstnSync;
  control_t    ctrlReg;
  control_t    ctrlNext;
  mode_state_t stateReg;
  mode_state_t stateNext;
  logic [15:0] settleCountReg;
  logic [15:0] settleCountNext;
  logic [3:0]  ocFlagReg;
  logic [3:0]  ocFlagNext;
  logic        uvFlagReg;
  logic        uvFlagNext;
  logic        ovFlagReg;
  logic        ovFlagNext;
  gate_t       gateNext;
  logic [15:0] rdataNext;
  logic        notReadyNext;
  logic        summaryNext;
  logic        readClear;
  logic        uvBlock;
  logic        ovBlock;
  logic [15:0] settleSeenReg;
  logic [15:0] settleSeenNext;

  // Gate pattern from the request bits and freewheel setting, before faults
  function automatic gate_t steer(control_t c, logic pwmIn, logic dual);
    gate_t g;
    g.highOne = c.highGateOneRequest & ~c.lowGateOneRequest;
    g.lowOne  = c.lowGateOneRequest & ~c.highGateOneRequest;
    g.highTwo = c.highGateTwoRequest & ~c.lowGateTwoRequest;
    g.lowTwo  = c.lowGateTwoRequest & ~c.highGateTwoRequest;
    if (!dual && !pwmIn) begin
      if (c.activeFreewheelEnable) begin
        g = c.freewheelSideSelect ? GATES_HIGH : GATES_LOW;
      end else if (c.freewheelSideSelect) begin
        g = g & GATES_HIGH;
      end else begin
        g = g & GATES_LOW;
      end
    end
    return g;
  endfunction

  function automatic logic [15:0] status_word(logic [3:0] oc, logic uv, logic ov);
    logic [15:0] w;
    w = STATUS_RESET;
    w[OC_LSB +: 4] = oc;
    w[UV_BIT] = uv;
    w[OV_BIT] = ov;
    return w;
  endfunction

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstnMeta <= 1'b0;
      rstnSync <= 1'b0;
    end else begin
      rstnMeta <= 1'b1;
      rstnSync <= rstnMeta;
    end
  end

  always_comb begin
    ctrlNext        = ctrlReg;
    stateNext       = stateReg;
    settleCountNext = settleCountReg;
    if (regWrite && regAddr == CONTROL_ADDR) begin
      ctrlNext = control_t'(regWdata & CONTROL_WR_MASK);
    end
    unique case (stateReg)
      STANDBY: begin
        settleCountNext = 16'h0000;
        if (ctrlReg.modeActive) begin
          stateNext = SETTLING;
        end
      end
      SETTLING: begin
        if (!ctrlReg.modeActive) begin
          stateNext = STANDBY;
        end else if (settleCountReg == 16'(SETTLE_CYCLES - 1)) begin
          stateNext = ACTIVE;
        end else begin
          settleCountNext = settleCountReg + 16'h0001;
        end
      end
      ACTIVE: begin
        if (!ctrlReg.modeActive) begin
          stateNext = STANDBY;
        end
      end
    endcase
  end

  // Status flags clear on read; a fault seen in the same cycle still sets
  always_comb begin
    readClear  = regRead && regAddr == STATUS_ADDR;
    ocFlagNext = (ocFlagReg & ~{4{readClear}}) | overcurrentDetect;
    uvFlagNext = (uvFlagReg & ~readClear) | undervoltageDetect;
    ovFlagNext = (ovFlagReg & ~readClear) | overvoltageDetect;
    if (stateNext == STANDBY) begin
      ocFlagNext = 4'h0;
      uvFlagNext = 1'b0;
      ovFlagNext = 1'b0;
    end
    summaryNext = |ocFlagNext | uvFlagNext | ovFlagNext;
  end

  always_comb begin
    uvBlock = undervoltageDetect |
              (ctrlReg.undervoltageAutorecoverOff & uvFlagNext);
    ovBlock = overvoltageDetect |
              (ctrlReg.overvoltageAutorecoverOff & ovFlagNext);
    notReadyNext = stateNext != ACTIVE;
    gateNext = GATES_OFF;
    if (!notReadyNext && !uvBlock && !ovBlock) begin
      gateNext = steer(ctrlReg, pwm, dualHalfBridge) & ~gate_t'(ocFlagNext);
    end
    rdataNext = 16'h0000;
    if (regRead) begin
      if (regAddr == CONTROL_ADDR) begin
        rdataNext = ctrlReg;
      end else if (regAddr == STATUS_ADDR) begin
        rdataNext = status_word(ocFlagReg, uvFlagReg, ovFlagReg);
      end
    end
  end

  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      ctrlReg        <= control_t'(CONTROL_RESET);
      stateReg       <= STANDBY;
      settleCountReg <= 16'h0000;
      ocFlagReg      <= 4'h0;
      uvFlagReg      <= 1'b0;
      ovFlagReg      <= 1'b0;
      gateOut        <= GATES_OFF;
      regRdata       <= 16'h0000;
      notReady       <= 1'b1;
      faultSummary   <= 1'b0;
    end else begin
      ctrlReg        <= ctrlNext;
      stateReg       <= stateNext;
      settleCountReg <= settleCountNext;
      ocFlagReg      <= ocFlagNext;
      uvFlagReg      <= uvFlagNext;
      ovFlagReg      <= ovFlagNext;
      gateOut        <= gateNext;
      regRdata       <= rdataNext;
      notReady       <= notReadyNext;
      faultSummary   <= summaryNext;
    end
  end

  // Independent count of Settling cycles, kept only for the timing check
  always_comb begin
    settleSeenNext = (stateReg == SETTLING) ? settleSeenReg + 16'h0001 : 16'h0000;
  end

  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      settleSeenReg <= 16'h0000;
    end else begin
      settleSeenReg <= settleSeenNext;
    end
  end

  AST_NO_SHOOT_THROUGH: assert property (@(posedge clk) disable iff (!rstnSync)
    !(gateOut.highOne && gateOut.lowOne) && !(gateOut.highTwo && gateOut.lowTwo))
    else $error("Both gates of one half-bridge are on");

  AST_ACTIVE_LOW_FREEWHEEL: assert property (@(posedge clk) disable iff (!rstnSync)
    (stateReg == ACTIVE && ctrlReg.modeActive && ctrlReg.activeFreewheelEnable &&
     !ctrlReg.freewheelSideSelect && !pwm && !dualHalfBridge && ocFlagNext == 4'h0 &&
     !undervoltageDetect && !overvoltageDetect && !uvFlagNext && !ovFlagNext)
    |=> gateOut == GATES_LOW)
    else $error("Active low-side freewheel pattern wrong");

  AST_OC_SWITCH_OFF: assert property (@(posedge clk) disable iff (!rstnSync)
    overcurrentDetect[3] |=> !gateOut.highOne)
    else $error("Over-current output still on");

  AST_OC_HELD_OFF: assert property (@(posedge clk) disable iff (!rstnSync)
    (ocFlagReg[0] && !readClear) |=> !gateOut.lowTwo)
    else $error("Output on while its over-current flag is set");

  AST_SUMMARY: assert property (@(posedge clk) disable iff (!rstnSync)
    faultSummary == (|ocFlagReg | uvFlagReg | ovFlagReg))
    else $error("Fault summary does not match flags");

  AST_UV_OFF: assert property (@(posedge clk) disable iff (!rstnSync)
    undervoltageDetect |=> gateOut == GATES_OFF ##0 (uvFlagReg || stateReg == STANDBY))
    else $error("Under-voltage did not switch off or latch");

  AST_OV_NO_RECOVERY: assert property (@(posedge clk) disable iff (!rstnSync)
    (ovFlagReg && ctrlReg.overvoltageAutorecoverOff && !readClear) |=> gateOut == GATES_OFF)
    else $error("Outputs resumed without over-voltage flag clear");

  AST_STANDBY_OFF: assert property (@(posedge clk) disable iff (!rstnSync)
    !ctrlReg.modeActive |=> (gateOut == GATES_OFF && notReady && ocFlagReg == 4'h0))
    else $error("Standby did not clear state and outputs");

  AST_SETTLE_TIME: assert property (@(posedge clk) disable iff (!rstnSync)
    (stateReg == STANDBY && ctrlReg.modeActive) ##1 ctrlReg.modeActive [*2] |->
    notReady)
    else $error("Not-ready cleared too early");

  AST_ENTER_ACTIVE: assert property (@(posedge clk) disable iff (!rstnSync)
    (stateReg == STANDBY && ctrlReg.modeActive) |=> stateReg == SETTLING)
    else $error("Mode bit did not start Active entry");

  AST_ACTIVE_HIGH_FREEWHEEL: assert property (@(posedge clk) disable iff (!rstnSync)
    (stateReg == ACTIVE && ctrlReg.modeActive && ctrlReg.activeFreewheelEnable &&
     ctrlReg.freewheelSideSelect && !pwm && !dualHalfBridge && ocFlagNext == 4'h0 &&
     !undervoltageDetect && !overvoltageDetect && !uvFlagNext && !ovFlagNext)
    |=> gateOut == GATES_HIGH)
    else $error("Active high-side freewheel pattern wrong");

  AST_PASSIVE_LOW_FREEWHEEL: assert property (@(posedge clk) disable iff (!rstnSync)
    (!ctrlReg.activeFreewheelEnable && !ctrlReg.freewheelSideSelect && !pwm &&
     !dualHalfBridge) |=> (!gateOut.highOne && !gateOut.highTwo))
    else $error("Passive low-side freewheel left a high gate on");

  AST_PASSIVE_HIGH_FREEWHEEL: assert property (@(posedge clk) disable iff (!rstnSync)
    (!ctrlReg.activeFreewheelEnable && ctrlReg.freewheelSideSelect && !pwm &&
     !dualHalfBridge) |=> (!gateOut.lowOne && !gateOut.lowTwo))
    else $error("Passive high-side freewheel left a low gate on");

  AST_UV_NO_RECOVERY: assert property (@(posedge clk) disable iff (!rstnSync)
    (uvFlagReg && ctrlReg.undervoltageAutorecoverOff && !readClear) |=> gateOut == GATES_OFF)
    else $error("Outputs resumed without under-voltage flag clear");

  AST_UV_RECOVER: assert property (@(posedge clk) disable iff (!rstnSync)
    (stateReg == ACTIVE && ctrlReg.modeActive && uvFlagReg && !undervoltageDetect &&
     !ctrlReg.undervoltageAutorecoverOff && !overvoltageDetect && !ovFlagNext &&
     ctrlReg.highGateOneRequest && !ctrlReg.lowGateOneRequest && pwm && !ocFlagNext[3])
    |=> gateOut.highOne)
    else $error("Outputs did not resume after under-voltage");

  AST_OV_RECOVER: assert property (@(posedge clk) disable iff (!rstnSync)
    (stateReg == ACTIVE && ctrlReg.modeActive && ovFlagReg && !overvoltageDetect &&
     !ctrlReg.overvoltageAutorecoverOff && !undervoltageDetect && !uvFlagNext &&
     ctrlReg.highGateOneRequest && !ctrlReg.lowGateOneRequest && pwm && !ocFlagNext[3])
    |=> gateOut.highOne)
    else $error("Outputs did not resume after over-voltage");

  AST_DUAL_IGNORES_FREEWHEEL: assert property (@(posedge clk) disable iff (!rstnSync)
    (dualHalfBridge && !ctrlReg.lowGateOneRequest) |=> !gateOut.lowOne)
    else $error("Freewheel logic drove a gate in dual half-bridge mode");

  AST_FAULT_PRIORITY: assert property (@(posedge clk) disable iff (!rstnSync)
    (ocFlagReg != 4'h0 && !readClear) |=> (gateOut & $past(ocFlagReg)) == 4'h0)
    else $error("Output on while a latched over-current flag is set");

  AST_NOT_READY_OFF: assert property (@(posedge clk) disable iff (!rstnSync)
    notReady |-> gateOut == GATES_OFF)
    else $error("Gate driven while not ready");

  AST_SETTLE_COUNT: assert property (@(posedge clk) disable iff (!rstnSync)
    $fell(notReady) |-> settleSeenReg == 16'(SETTLE_CYCLES))
    else $error("Settling time differs from the configured count");

  COV_ACTIVE_REACHED: cover property (@(posedge clk) disable iff (!rstnSync)
    $fell(notReady));
  COV_OC_TRIP: cover property (@(posedge clk) disable iff (!rstnSync)
    gateOut.highOne ##1 ocFlagReg[3]);
  COV_UV_RECOVER: cover property (@(posedge clk) disable iff (!rstnSync)
    uvFlagReg ##1 gateOut != GATES_OFF);
  COV_ACTIVE_FREEWHEEL: cover property (@(posedge clk) disable iff (!rstnSync)
    !pwm && gateOut == GATES_HIGH);
  COV_STANDBY_RETURN: cover property (@(posedge clk) disable iff (!rstnSync)
    $rose(notReady));

endmodule

// >>> common/hbridge_pkg.sv
package hbridge_pkg;

  localparam logic [5:0]  CONTROL_ADDR    = 6'h00;
  localparam logic [5:0]  STATUS_ADDR     = 6'h10;
  localparam logic [15:0] CONTROL_RESET   = 16'h0000;
  localparam logic [15:0] STATUS_RESET    = 16'h0000;
  localparam logic [15:0] CONTROL_WR_MASK = 16'h03df;
  localparam int          OC_LSB          = 6;
  localparam int          UV_BIT          = 3;
  localparam int          OV_BIT          = 2;
  localparam int          SETTLE_DEFAULT  = 400;

  typedef struct packed {
    logic [5:0] unusedHigh;
    logic       highGateOneRequest;
    logic       lowGateOneRequest;
    logic       highGateTwoRequest;
    logic       lowGateTwoRequest;
    logic       unusedFive;
    logic       freewheelSideSelect;
    logic       activeFreewheelEnable;
    logic       overvoltageAutorecoverOff;
    logic       undervoltageAutorecoverOff;
    logic       modeActive;
  } control_t;

  // Same order as the over-current flags: high one, low one, high two, low two
  typedef struct packed {
    logic highOne;
    logic lowOne;
    logic highTwo;
    logic lowTwo;
  } gate_t;

  localparam gate_t GATES_OFF  = 4'h0;
  localparam gate_t GATES_LOW  = 4'h5;
  localparam gate_t GATES_HIGH = 4'ha;

  typedef enum logic [1:0] {
    STANDBY,
    SETTLING,
    ACTIVE
  } mode_state_t;

endpackage

// >>> test/hbridge_host_model.sv
`timescale 1ns/1ns
module hbridge_host_model
  import hbridge_pkg::*;
(
  input  wire logic        clk,
  output logic             regWrite,
  output logic             regRead,
  output logic      [5:0]  regAddr,
  output logic      [15:0] regWdata,
  input  wire logic [15:0] regRdata
);
  initial begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    regAddr  = 6'h3f;
    regWdata = 16'hffff;
  end
  // Released lines show the inverse so stale values cannot pass as held ones
  task automatic writeReg(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    regAddr  <= ~a;
    regWdata <= ~d;
  endtask
  // Reading status clears latched faults; writing the mode bit clear (Standby) also clears them
  task automatic readReg(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdata;
  endtask
endmodule

// >>> test/tb_hbridge_control_fault_regs.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb_hbridge_control_fault_regs;
  import hbridge_pkg::*;
  logic        clk, rstn, pwm, dual, uvDet, ovDet, regWrite, regRead;
  logic        notReady, faultSummary;
  logic [3:0]  ocDet;
  logic [5:0]  regAddr;
  logic [15:0] regWdata, regRdata, rd;
  gate_t       gateOut;
  int          n_errors, check_count, cycles;
  localparam int SETTLE_SIM = 4;

  hbridge_host_model u_hbridge_host_model (.clk(clk), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));
  hbridge_control_fault_regs #(.SETTLE_CYCLES(SETTLE_SIM)) u_hbridge_control_fault_regs (
    .clk(clk),
    .rstn(rstn), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .pwm(pwm), .dualHalfBridge(dual),
    .overcurrentDetect(ocDet), .undervoltageDetect(uvDet), .overvoltageDetect(ovDet),
    .gateOut(gateOut), .notReady(notReady), .faultSummary(faultSummary));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic ctl(input logic [15:0] d);
    u_hbridge_host_model.writeReg(CONTROL_ADDR, d);
    waitc(3);
  endtask
  task automatic rdReg(input logic [5:0] a);
    u_hbridge_host_model.readReg(a, rd);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      results();
    end
  end

  task automatic t_regs;
    rdReg(CONTROL_ADDR);
    `CHK("control reset", CONTROL_RESET, rd)
    rdReg(STATUS_ADDR);
    `CHK("status reset", STATUS_RESET, rd)
    `CHK("standby notReady", 1'b1, notReady)
    ctl(16'hfc20);
    rdReg(CONTROL_ADDR);
    `CHK("reserved bits", 16'h0000, rd)
    rdReg(6'h3f);
    `CHK("unmapped read", 16'h0000, rd)
    $display("test regs done");
  endtask
  task automatic t_mode;
    int n;
    u_hbridge_host_model.writeReg(CONTROL_ADDR, 16'h0001);
    n = 0;
    while (notReady === 1'b1 && n < 20) begin
      waitc(1);
      n++;
    end
    `CHK("settle cycles", SETTLE_SIM + 1, n)
    `CHK("ready", 1'b0, notReady)
    $display("test mode done");
  endtask
  task automatic t_gates;
    logic [3:0] r;
    logic [3:0] e;
    for (int i = 0; i < 16; i++) begin
      r = i[3:0];
      e = {r[3] & ~r[2], r[2] & ~r[3], r[1] & ~r[0], r[0] & ~r[1]};
      ctl(16'h0001 | {6'h00, r, 6'h00});
      `CHK("gate decode", e, gateOut)
    end
    $display("test gates done");
  endtask
  task automatic t_freewheel;
    logic [3:0] ex [4];
    ex = '{4'h1, 4'h8, 4'h5, 4'ha};
    @(posedge clk) pwm <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      ctl(16'h0241 | {11'h000, k[0], k[1], 3'h0});
      `CHK("freewheel", ex[k], gateOut)
    end
    @(posedge clk) dual <= 1'b1;
    ctl(16'h0249);
    `CHK("dual half bridge", 4'h9, gateOut)
    @(posedge clk) dual <= 1'b0;
    @(posedge clk) pwm <= 1'b1;
    $display("test freewheel done");
  endtask
  task automatic t_oc;
    ctl(16'h0281);
    @(posedge clk) ocDet <= 4'h8;
    waitc(2);
    @(posedge clk) ocDet <= 4'h0;
    waitc(3);
    `CHK("oc gate off", 4'h2, gateOut)
    `CHK("summary", 1'b1, faultSummary)
    rdReg(STATUS_ADDR);
    `CHK("oc flag", 16'h0200, rd)
    waitc(3);
    `CHK("oc resume", GATES_HIGH, gateOut)
    `CHK("summary clear", 1'b0, faultSummary)
    $display("test overcurrent done");
  endtask
  task automatic t_supply(input logic isUv);
    logic [15:0] offBit, flag;
    offBit = isUv ? 16'h0002 : 16'h0004;
    flag = isUv ? 16'h0008 : 16'h0004;
    for (int off = 0; off < 2; off++) begin
      ctl(16'h0281 | (off != 0 ? offBit : 16'h0000));
      @(posedge clk) {uvDet, ovDet} <= {isUv, ~isUv};
      waitc(3);
      `CHK("supply off", GATES_OFF, gateOut)
      `CHK("supply summary", 1'b1, faultSummary)
      @(posedge clk) {uvDet, ovDet} <= 2'b00;
      waitc(3);
      `CHK("recovery", off != 0 ? GATES_OFF : GATES_HIGH, gateOut)
      rdReg(STATUS_ADDR);
      `CHK("supply flag", flag, rd)
      waitc(3);
      `CHK("resume", GATES_HIGH, gateOut)
      `CHK("supply summary clear", 1'b0, faultSummary)
    end
    $display("test supply done");
  endtask
  task automatic t_standby;
    @(posedge clk) ocDet <= 4'h1;
    @(posedge clk) ocDet <= 4'h0;
    waitc(1);
    `CHK("summary before standby", 1'b1, faultSummary)
    ctl(16'h0280);
    `CHK("standby gates", GATES_OFF, gateOut)
    `CHK("standby notReady", 1'b1, notReady)
    `CHK("standby summary", 1'b0, faultSummary)
    rdReg(STATUS_ADDR);
    `CHK("standby flags", STATUS_RESET, rd)
    $display("test standby done");
  endtask

  initial begin
    {rstn, pwm, dual, uvDet, ovDet} = 5'b01000;
    ocDet = 4'h0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    waitc(3);
    t_regs();
    t_mode();
    t_gates();
    t_freewheel();
    t_oc();
    t_supply(1'b1);
    t_supply(1'b0);
    t_standby();
    results();
  end
endmodule
